// *** hdl/acr_pkg.sv ***
// Overview of operation
// R01 - twelve-bit result held in two read-only bytes
// R02 - format 0: result left justified
// R03 - format 1: result right justified
// R04 - unused result bits read zero
// R05 - conversion launches on start falling edge
// R06 - start high holds converter reset, busy set
// R07 - busy flag read-only, high during conversion
// R08 - power-off bit resets to one
// R09 - software powers off before idle or sleep
// R10 - sixteen channels: four-bit code selects pin
// R11 - eight channels: three-bit code, bit3 zero
// R12 - channel plus bandgap bit pick one input
// R13 - analog enable takes pin from digital function
// R14 - analog enable removes pin pull-high
// R15 - bandgap select routes bandgap, others cut
// R16 - end of conversion clears busy, raises event
// R17 - clock divider codes 000-110, 111 undefined
// R18 - result loaded once per conversion end
// R19 - starts ignored while powered off
package acr_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ACR_OFS_RES_LO = 4'h0;
  localparam logic [3:0] ACR_OFS_RES_HI = 4'h1;
  localparam logic [3:0] ACR_OFS_CTRL0 = 4'h2;
  localparam logic [3:0] ACR_OFS_CTRL1 = 4'h3;
  localparam logic [3:0] ACR_OFS_AEN_LO = 4'h4;
  localparam logic [3:0] ACR_OFS_AEN_HI = 4'h5;
  localparam logic [3:0] ACR_OFS_IRQ_STAT = 4'h6;
  localparam logic [3:0] ACR_OFS_IRQ_MASK = 4'h7;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ACR_BIT_START = 7;
  localparam int ACR_BIT_BUSY = 6;
  localparam int ACR_BIT_OFF = 5;
  localparam int ACR_BIT_FMT = 4;
  localparam int ACR_BIT_BGSEL = 7;
  localparam int ACR_BIT_BGEN = 6;
  localparam int ACR_BIT_VREFS = 4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ACR_RST_CTRL0 = 8'h60;
  localparam logic [7:0] ACR_RST_CTRL1 = 8'h00;
  localparam logic [7:0] ACR_RST_AEN = 8'hFF;
  localparam logic [7:0] ACR_RST_MASK = 8'h00;
  // ---------------------------------------------------------------
  // timing: converter clocks per conversion
  // ---------------------------------------------------------------
  localparam int ACR_CONV_ADCK = 16;
  localparam logic [2:0] ACR_DIV_BAD = 3'h7;
  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acr_req_t;
  // converter run state
  typedef enum logic [1:0] {
    ACR_ST_IDLE = 2'b00,
    ACR_ST_HOLD = 2'b01,
    ACR_ST_CONV = 2'b10
  } acr_state_t;
endpackage : acr_pkg

// *** hdl/acr_clkdiv.sv ***
`timescale 1ns/1ps
// converter clock tick generator
module acr_clkdiv (
  input wire logic core_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic run, // divider runs while high
  input wire logic [2:0] sel, // divide code
  output logic tick // one-cycle converter clock tick
);
  logic [5:0] cnt_r; // prescale counter
  logic [5:0] lim; // terminal count for code
  // ---------------------------------------------------------------
  // divide 1,2,4..64; code 111 gives no tick
  // ---------------------------------------------------------------
  always_comb begin
    lim = 6'((7'h01 << sel) - 7'h01); // R17
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 6'h00;
    end else if (!run || cnt_r >= lim) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
  assign tick = run && (cnt_r >= lim) && (sel != acr_pkg::ACR_DIV_BAD); // R17
endmodule : acr_clkdiv

// *** hdl/acr_top.sv ***
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// converter control and result registers
module acr_top #(
  parameter int NUM_CH = 16 // 16 or 8 pin channels
) (
  input wire logic core_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic [11:0] conv_data, // converter core result
  output logic conv_reset, // converter held in reset
  output logic conv_power_off, // converter powered down
  output logic conv_sample, // one-cycle converter clock tick
  output logic [4:0] conv_input_sel, // selected input, 16 = bandgap
  output logic bandgap_enable, // bandgap circuit on
  output logic vref_pin_select, // external reference chosen
  output logic [15:0] analog_pin_enable, // pin given to converter
  output logic [15:0] pull_high_allow, // pull-high may act on pin
  output logic irq // level interrupt
);
  localparam int CW = (NUM_CH > 8) ? 4 : 3; // channel field width
  localparam logic [7:0] CH_MASK = (NUM_CH > 8) ? 8'h0F : 8'h07;
  localparam logic [15:0] PIN_MASK = (NUM_CH > 8) ? 16'hFFFF : 16'h00FF;

  acr_pkg::acr_req_t req; // bundled bus request
  acr_pkg::acr_state_t state_r; // run state
  logic start_r; // start control bit
  logic busy_r; // conversion busy flag
  logic off_r; // power-off bit
  logic fmt_r; // result format select
  logic [CW-1:0] chan_r; // channel select field
  logic [7:0] ctrl1_r; // secondary control register
  logic [15:0] aen_r; // analog pin enable bits
  logic [11:0] result_r; // latched conversion result
  logic [4:0] adck_cnt_r; // converter clocks in conversion
  logic [1:0] stat_r; // sticky events: 0 done, 1 start ignored
  logic [1:0] mask_r; // interrupt mask
  logic [7:0] rdata_r; // read data register
  logic [7:0] res_lo; // formatted low byte
  logic [7:0] res_hi; // formatted high byte
  logic [7:0] rd_mux; // read mux
  logic tick; // converter clock tick
  logic wr_ctrl0; // write to primary control
  logic launch; // start falling edge while powered
  logic done; // conversion end
  logic ign_start; // start written while powered off

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign wr_ctrl0 = req.wr && req.addr == acr_pkg::ACR_OFS_CTRL0;

  // ---------------------------------------------------------------
  // start sequencing
  // ---------------------------------------------------------------
  // falling start edge launches only when powered up
  assign launch = wr_ctrl0 && start_r && !req.wdata[acr_pkg::ACR_BIT_START]
    && !off_r; // R05 R19
  assign ign_start = wr_ctrl0 && off_r && req.wdata[acr_pkg::ACR_BIT_START];
  assign done = state_r == acr_pkg::ACR_ST_CONV && tick
    && adck_cnt_r == 5'(acr_pkg::ACR_CONV_ADCK - 1);

  // control fields of primary register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      start_r <= acr_pkg::ACR_RST_CTRL0[acr_pkg::ACR_BIT_START];
      off_r <= acr_pkg::ACR_RST_CTRL0[acr_pkg::ACR_BIT_OFF]; // R08
      fmt_r <= acr_pkg::ACR_RST_CTRL0[acr_pkg::ACR_BIT_FMT];
      chan_r <= acr_pkg::ACR_RST_CTRL0[CW-1:0];
    end else if (wr_ctrl0) begin
      start_r <= req.wdata[acr_pkg::ACR_BIT_START];
      off_r <= req.wdata[acr_pkg::ACR_BIT_OFF]; // R08
      fmt_r <= req.wdata[acr_pkg::ACR_BIT_FMT];
      chan_r <= req.wdata[CW-1:0]; // R10 R11
    end
  end

  // run state: hold while start high, convert after its fall
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= acr_pkg::ACR_ST_IDLE;
    end else if (off_r || (wr_ctrl0 && req.wdata[acr_pkg::ACR_BIT_OFF])) begin
      state_r <= acr_pkg::ACR_ST_IDLE; // R19
    end else if (wr_ctrl0 && req.wdata[acr_pkg::ACR_BIT_START]) begin
      state_r <= acr_pkg::ACR_ST_HOLD; // R06
    end else if (launch) begin
      state_r <= acr_pkg::ACR_ST_CONV; // R05
    end else if (done) begin
      state_r <= acr_pkg::ACR_ST_IDLE;
    end
  end

  // converter clocks counted through a conversion
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      adck_cnt_r <= 5'h00;
    end else if (state_r != acr_pkg::ACR_ST_CONV) begin
      adck_cnt_r <= 5'h00;
    end else if (tick) begin
      adck_cnt_r <= adck_cnt_r + 5'h01;
    end
  end

  // busy flag: set on start, reset or power-off, cleared at end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= acr_pkg::ACR_RST_CTRL0[acr_pkg::ACR_BIT_BUSY];
    end else if (off_r || (wr_ctrl0 && req.wdata[acr_pkg::ACR_BIT_OFF])) begin
      busy_r <= 1'b1; // R19
    end else if (wr_ctrl0 && req.wdata[acr_pkg::ACR_BIT_START]) begin
      busy_r <= 1'b1; // R06
    end else if (done) begin
      busy_r <= 1'b0; // R16 R07
    end
  end

  // result latched only at conversion end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result_r <= 12'h000;
    end else if (done) begin
      result_r <= conv_data; // R18 R01
    end
  end

  acr_clkdiv acr_clkdiv_inst (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(state_r == acr_pkg::ACR_ST_CONV),
    .sel(ctrl1_r[2:0]),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // secondary control and pin enables
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl1_r <= acr_pkg::ACR_RST_CTRL1;
    end else if (req.wr && req.addr == acr_pkg::ACR_OFS_CTRL1) begin
      ctrl1_r <= req.wdata & 8'hD7; // bits 5 and 3 unimplemented
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aen_r <= {acr_pkg::ACR_RST_AEN, acr_pkg::ACR_RST_AEN} & PIN_MASK;
    end else if (req.wr && req.addr == acr_pkg::ACR_OFS_AEN_LO) begin
      aen_r[7:0] <= req.wdata;
    end else if (req.wr && req.addr == acr_pkg::ACR_OFS_AEN_HI) begin
      aen_r[15:8] <= req.wdata & PIN_MASK[15:8];
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  // set wins over clear-on-read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stat_r <= 2'b00;
    end else begin
      stat_r <= ((req.rd && req.addr == acr_pkg::ACR_OFS_IRQ_STAT)
        ? 2'b00 : stat_r) | {ign_start, done}; // R16
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mask_r <= acr_pkg::ACR_RST_MASK[1:0];
    end else if (req.wr && req.addr == acr_pkg::ACR_OFS_IRQ_MASK) begin
      mask_r <= req.wdata[1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // ---------------------------------------------------------------
  // result formatting
  // ---------------------------------------------------------------
  always_comb begin
    if (fmt_r) begin
      res_hi = {4'h0, result_r[11:8]}; // R03 R04
      res_lo = result_r[7:0]; // R03
    end else begin
      res_hi = result_r[11:4]; // R02
      res_lo = {result_r[3:0], 4'h0}; // R02 R04
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    unique case (req.addr)
      acr_pkg::ACR_OFS_RES_LO: rd_mux = res_lo;
      acr_pkg::ACR_OFS_RES_HI: rd_mux = res_hi;
      acr_pkg::ACR_OFS_CTRL0: rd_mux = {start_r, busy_r, off_r, fmt_r,
        4'h0} | (8'(chan_r) & CH_MASK); // R07 R11
      acr_pkg::ACR_OFS_CTRL1: rd_mux = ctrl1_r;
      acr_pkg::ACR_OFS_AEN_LO: rd_mux = aen_r[7:0];
      acr_pkg::ACR_OFS_AEN_HI: rd_mux = aen_r[15:8];
      acr_pkg::ACR_OFS_IRQ_STAT: rd_mux = {6'h00, stat_r};
      acr_pkg::ACR_OFS_IRQ_MASK: rd_mux = {6'h00, mask_r};
      default: rd_mux = 8'h00; // unmapped reads zero
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (req.rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // converter and pin controls
  // ---------------------------------------------------------------
  assign conv_reset = state_r != acr_pkg::ACR_ST_CONV; // R06
  assign conv_power_off = off_r; // R08
  assign conv_sample = tick;
  // bandgap disconnects every pin channel
  assign conv_input_sel = ctrl1_r[acr_pkg::ACR_BIT_BGSEL] ? 5'h10
    : 5'(chan_r); // R12 R15 R10
  assign bandgap_enable = ctrl1_r[acr_pkg::ACR_BIT_BGEN];
  assign vref_pin_select = ctrl1_r[acr_pkg::ACR_BIT_VREFS];
  assign analog_pin_enable = aen_r; // R13
  assign pull_high_allow = ~aen_r; // R14
endmodule : acr_top

// *** bench/acr_monitor.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker for the converter control block
// ---------------------------------------------------------------
module acr_monitor #(
  parameter int NUM_CH = 16 // 16 or 8 pin channels
) (
  input wire logic core_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [11:0] conv_data, // converter core result
  input wire logic conv_reset, // converter held in reset
  input wire logic conv_power_off, // converter powered down
  input wire logic conv_sample, // converter clock tick
  input wire logic [4:0] conv_input_sel, // selected input
  input wire logic bandgap_enable, // bandgap circuit on
  input wire logic vref_pin_select, // external reference chosen
  input wire logic [15:0] analog_pin_enable, // pin given to converter
  input wire logic [15:0] pull_high_allow, // pull-high may act
  input wire logic irq // level interrupt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic ctrl0_wr; // write aimed at the primary control register
  assign ctrl0_wr = reg_wr && (reg_addr == acr_pkg::ACR_OFS_CTRL0);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_start_holds_reset: assert property
    (ctrl0_wr && reg_wdata[7] |=> conv_reset)
    else $error("start write did not hold converter reset");
  chk_power_bit_follows: assert property
    (ctrl0_wr |=> conv_power_off == $past(reg_wdata[5]))
    else $error("power-off output does not follow write");
  chk_busy_while_off: assert property
    (reg_rd && reg_addr == acr_pkg::ACR_OFS_CTRL0 && conv_power_off
      |=> reg_rdata[6])
    else $error("busy read low while powered off");
  chk_tick_off_quiet: assert property
    (conv_power_off |-> !conv_sample)
    else $error("converter tick while powered off");
  chk_tick_needs_run: assert property
    (conv_sample |-> !conv_reset)
    else $error("converter tick while held in reset");
  chk_pin_enable_write: assert property
    (reg_wr && reg_addr == acr_pkg::ACR_OFS_AEN_LO
      |=> analog_pin_enable[7:0] == $past(reg_wdata))
    else $error("pin enable low byte not taken");
  chk_pull_high_cut: assert property
    (pull_high_allow == ~analog_pin_enable)
    else $error("pull-high left on an analog pin");
  chk_bandgap_routed: assert property
    (reg_wr && reg_addr == acr_pkg::ACR_OFS_CTRL1 && reg_wdata[7]
      |=> conv_input_sel == 5'h10)
    else $error("bandgap not routed");
  chk_channel_code: assert property
    (ctrl0_wr && !conv_input_sel[4]
      |=> conv_input_sel == (NUM_CH == 8 ? {2'b00, $past(reg_wdata[2:0])}
        : {1'b0, $past(reg_wdata[3:0])}))
    else $error("channel code not routed");
  chk_mask_silences: assert property
    (reg_wr && reg_addr == acr_pkg::ACR_OFS_IRQ_MASK && reg_wdata == 8'h00
      |=> !irq)
    else $error("interrupt high with all masked");
endmodule : acr_monitor

// *** bench/acr_top_bench.sv ***
`timescale 1ns/1ps
module acr_top_bench;
  localparam int NUM_CH = 16; // sixteen pin variant
  logic core_clk, resetn, reg_wr, reg_rd, conv_reset, conv_power_off;
  logic conv_sample, bandgap_enable, vref_pin_select, irq, fmt, bg, mk;
  logic [3:0] reg_addr, ch;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [11:0] conv_data, d;
  logic [4:0] conv_input_sel;
  logic [15:0] analog_pin_enable, pull_high_allow;
  logic [31:0] seed; // random state
  logic [2:0] dv; // divide code
  int fails, n_checks, ticks;
  localparam int NARROW_CH = 8; // eight pin variant
  logic [7:0] rdata_ch8; // read data of the eight pin variant
  logic [4:0] sel_ch8; // input select of the eight pin variant
  int t0; // tick count at conversion launch
  acr_top #(.NUM_CH(NUM_CH)) acr_top_inst (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_data(conv_data), .conv_reset(conv_reset),
    .conv_power_off(conv_power_off), .conv_sample(conv_sample),
    .conv_input_sel(conv_input_sel), .bandgap_enable(bandgap_enable),
    .vref_pin_select(vref_pin_select), .analog_pin_enable(analog_pin_enable),
    .pull_high_allow(pull_high_allow), .irq(irq));
  // eight pin variant shares the bus, only its channel view is compared
  acr_top #(.NUM_CH(NARROW_CH)) acr_top_ch8_inst (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata_ch8), .conv_data(conv_data), .conv_reset(),
    .conv_power_off(), .conv_sample(), .conv_input_sel(sel_ch8),
    .bandgap_enable(), .vref_pin_select(), .analog_pin_enable(),
    .pull_high_allow(), .irq());
  // ---------------------------------------------------------------
  // clock, tick counter and helpers
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // counts converter ticks of the wide variant
  always @(posedge core_clk) begin
    if (conv_sample === 1'b1) begin
      ticks <= ticks + 1;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  task automatic rchk(input string what, input logic [3:0] a,
    input logic [7:0] exp);
    logic [7:0] q;
    rd(a, q);
    check(what, q, exp);
  endtask : rchk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // watchdog: all tests need about 2400 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    conv_data = 12'h000;
    seed = 32'h0000FB9D;
    fails = 0;
    n_checks = 0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rchk("ctrl0 reset", acr_pkg::ACR_OFS_CTRL0, 8'h60);
    rchk("ctrl1 reset", acr_pkg::ACR_OFS_CTRL1, 8'h00);
    rchk("pins lo reset", acr_pkg::ACR_OFS_AEN_LO, 8'hFF);
    rchk("pins hi reset", acr_pkg::ACR_OFS_AEN_HI, 8'hFF);
    rchk("result hi reset", acr_pkg::ACR_OFS_RES_HI, 8'h00);
    rchk("unmapped", 4'hA, 8'h00);
    $display("test reset done");
    // start while powered off is refused, power bit kept set
    wr(acr_pkg::ACR_OFS_CTRL0, 8'hA0);
    #1 check("hold reset", conv_reset, 16'h0001);
    wr(acr_pkg::ACR_OFS_CTRL0, 8'h20);
    t0 = ticks;
    repeat (40) @(posedge core_clk);
    #1 check("ticks while off", 16'(ticks - t0), 16'h0000);
    rchk("refused start", acr_pkg::ACR_OFS_IRQ_STAT, 8'h02);
    rchk("busy while off", acr_pkg::ACR_OFS_CTRL0, 8'h60);
    // power up; busy stays set until a conversion ends
    wr(acr_pkg::ACR_OFS_CTRL0, 8'h00);
    rchk("busy after power up", acr_pkg::ACR_OFS_CTRL0, 8'h40);
    $display("test power off done");
    // one conversion per defined divide code, both formats
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      d = seed[11:0];
      ch = seed[16:13];
      fmt = i[1];
      dv = 3'(i);
      bg = (i == 2);
      mk = i[0];
      wr(acr_pkg::ACR_OFS_IRQ_MASK, {7'h00, mk});
      wr(acr_pkg::ACR_OFS_CTRL1, {bg, bg, 3'b000, dv});
      #1 check("bandgap on", bandgap_enable, bg);
      wr(acr_pkg::ACR_OFS_CTRL0, {3'b100, fmt, ch});
      #1 check("input select", conv_input_sel, bg ? 5'h10 : {1'b0, ch});
      rchk("busy on start", acr_pkg::ACR_OFS_CTRL0, {3'b110, fmt, ch});
      check("reset while held", conv_reset, 16'h0001);
      conv_data <= d;
      wr(acr_pkg::ACR_OFS_CTRL0, {3'b000, fmt, ch});
      #1 check("converting", conv_reset, 16'h0000);
      t0 = ticks;
      v = 8'hFF;
      for (int k = 0; k < 800 && v[6] !== 1'b0; k++) begin
        rd(acr_pkg::ACR_OFS_CTRL0, v);
      end
      check("busy end", v[6], 16'h0000);
      check("tick count", 16'(ticks - t0),
        16'(acr_pkg::ACR_CONV_ADCK));
      check("irq level", irq, mk);
      conv_data <= ~d;
      rchk("result hi", acr_pkg::ACR_OFS_RES_HI,
        fmt ? {4'h0, d[11:8]} : d[11:4]);
      rchk("result lo", acr_pkg::ACR_OFS_RES_LO,
        fmt ? d[7:0] : {d[3:0], 4'h0});
      rchk("status done", acr_pkg::ACR_OFS_IRQ_STAT, 8'h01);
      #1 check("irq cleared", irq, 16'h0000);
    end
    $display("test conversions done");
    wr(acr_pkg::ACR_OFS_CTRL0, 8'h40);
    rchk("busy read only", acr_pkg::ACR_OFS_CTRL0, 8'h00);
    // full channel code on both variants
    wr(acr_pkg::ACR_OFS_CTRL0, 8'h0F);
    rchk("wide channel field", acr_pkg::ACR_OFS_CTRL0, 8'h0F);
    check("narrow channel field", rdata_ch8, 16'h0007);
    check("wide route", conv_input_sel, 16'h000F);
    check("narrow route", sel_ch8, 16'h0007);
    $display("test channels done");
    seed = lfsr(seed);
    wr(acr_pkg::ACR_OFS_AEN_LO, seed[7:0]);
    wr(acr_pkg::ACR_OFS_AEN_HI, seed[15:8]);
    #1 check("pin enables", analog_pin_enable, seed[15:0]);
    check("pull-high", pull_high_allow, ~seed[15:0]);
    rchk("pins hi back", acr_pkg::ACR_OFS_AEN_HI, seed[15:8]);
    $display("test pins done");
    // every secondary bit set: bandgap, reference pin, divide code 111
    wr(acr_pkg::ACR_OFS_CTRL1, 8'hFF);
    rchk("ctrl1 fields", acr_pkg::ACR_OFS_CTRL1, 8'hD7);
    check("bandgap route", conv_input_sel, 16'h0010);
    check("vref select", vref_pin_select, 16'h0001);
    wr(acr_pkg::ACR_OFS_CTRL0, 8'h80);
    wr(acr_pkg::ACR_OFS_CTRL0, 8'h00);
    t0 = ticks;
    repeat (100) @(posedge core_clk);
    #1 check("no ticks code 7", 16'(ticks - t0), 16'h0000);
    rchk("stalled busy", acr_pkg::ACR_OFS_CTRL0, 8'h40);
    wr(acr_pkg::ACR_OFS_CTRL0, 8'h20);
    #1 check("powered down", conv_power_off, 16'h0001);
    rchk("busy when off", acr_pkg::ACR_OFS_CTRL0, 8'h60);
    $display("test divider and power done");
    complete_run();
  end
endmodule : acr_top_bench
bind acr_top acr_monitor #(.NUM_CH(NUM_CH)) acr_monitor_inst (
  .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_data(conv_data), .conv_reset(conv_reset),
  .conv_power_off(conv_power_off), .conv_sample(conv_sample),
  .conv_input_sel(conv_input_sel), .bandgap_enable(bandgap_enable),
  .vref_pin_select(vref_pin_select), .analog_pin_enable(analog_pin_enable),
  .pull_high_allow(pull_high_allow), .irq(irq));
